// File: tb/lps_ctrl_model.sv
`timescale 1ns/100ps

module lps_ctrl_model
  import lps_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // command side
  output logic ckeIn,
  output lps_cmd_pins_t cmdPins,
  output logic bankSelect0,
  output logic bankSelect1,
  output logic [ADDR_W-1:0] addr,
  output logic lowerByteMask,
  output logic upperByteMask,
  // data wire
  output logic [DQ_W-1:0] dqIn,
  input wire logic [DQ_W-1:0] dqOut,
  input wire logic [DQ_W-1:0] dqOe
);
  logic drv = 1'b0;
  logic [DQ_W-1:0] wd = 16'h0000;
  logic [DQ_W-1:0] park = 16'hA5A5;

  initial begin
    ckeIn = 1'b1;
    cmdPins = 4'hF;
    {bankSelect1, bankSelect0} = 2'h0;
    addr = 13'h0000;
    {upperByteMask, lowerByteMask} = 2'h3;
  end

  // a released wire shows a changing pattern
  always_ff @(posedge sys_clk) begin
    park <= ~park;
  end

  // wire level from both parties' enables
  always_comb begin
    for (int i = 0; i < DQ_W; i++) begin
      dqIn[i] = dqOe[i] ? dqOut[i] : (drv ? wd[i] : park[i]);
    end
  end

  // change after the falling edge, stable over the rising one
  task automatic issue(input logic [3:0] c, input logic [1:0] b,
      input logic [ADDR_W-1:0] a, input logic [1:0] m, input logic k);
    @(negedge sys_clk);
    cmdPins = c;
    {bankSelect1, bankSelect0} = b;
    addr = a;
    {upperByteMask, lowerByteMask} = m;
    ckeIn = k;
  endtask

  task automatic put(input logic d, input logic [DQ_W-1:0] v);
    drv = d;
    wd = v;
  endtask

  // power-up order: precharge all, two refreshes, both mode loads
  task automatic init(input logic [ADDR_W-1:0] md,
      input logic [ADDR_W-1:0] ex);
    issue({1'b0, CMD_PRECHARGE}, 2'h0, 13'h0400, 2'h3, 1'b1);
    repeat (2) begin
      issue({1'b0, CMD_REFRESH}, 2'h0, 13'h0000, 2'h3, 1'b1);
      repeat (3) issue({1'b0, CMD_NOP}, 2'h0, 13'h0000, 2'h3, 1'b1);
    end
    issue({1'b0, CMD_MODE_LOAD}, SEL_MODE, md, 2'h3, 1'b1);
    issue({1'b0, CMD_MODE_LOAD}, SEL_EXT, ex, 2'h3, 1'b1);
    issue({1'b0, CMD_NOP}, 2'h0, 13'h0000, 2'h0, 1'b1);
  endtask
endmodule // lps_ctrl_model

// File: tb/lps_sdram_if_checker.sv
`timescale 1ns/100ps

module lps_sdram_if_checker
  import lps_pkg::*;
#(
  parameter int STORE_ROW_BITS = 2,
  parameter int STORE_COL_BITS = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pins
  input wire logic ckeIn,
  input wire lps_cmd_pins_t cmdPins,
  input wire logic bankSelect0,
  input wire logic bankSelect1,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic lowerByteMask,
  input wire logic upperByteMask,
  input wire logic [DQ_W-1:0] dqIn,
  input wire logic [DQ_W-1:0] dqOut,
  input wire logic [DQ_W-1:0] dqOe,
  // status
  input wire lps_pwr_t powerState,
  input wire logic inputBuffersOn,
  input wire logic [NUM_BANKS-1:0] bankRowOpen,
  input wire logic burstActive,
  input wire logic [ADDR_W-1:0] modeRegOut,
  input wire logic [ADDR_W-1:0] extModeRegOut
);
  logic tk;
  logic [2:0] cd;
  logic [1:0] bk;
  logic act;
  assign act = powerState == PWR_ACTIVE;
  assign tk = ckeIn && act && !cmdPins.csN;
  assign cd = {cmdPins.rasN, cmdPins.casN, cmdPins.weN};
  assign bk = {bankSelect1, bankSelect0};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // read mask held over three edges
  sequence lowMasked;
    (lowerByteMask && ckeIn && act)[*3];
  endsequence
  sequence upMasked;
    (upperByteMask && ckeIn && act)[*3];
  endsequence

  mode_load_a: assert property (tk && cd == CMD_MODE_LOAD
    && bk == SEL_MODE |=> modeRegOut == $past(addr))
    else $error("mode load lost");
  ext_load_a: assert property (tk && cd == CMD_MODE_LOAD
    && bk == SEL_EXT |=> extModeRegOut == $past(addr) && $stable(modeRegOut))
    else $error("extended load wrong");
  row_open_a: assert property (tk && cd == CMD_ACTIVATE
    |=> bankRowOpen[$past(bk)]) else $error("activate missed bank");
  close_all_a: assert property (tk && cd == CMD_PRECHARGE
    && addr[AUTO_PRE_BIT] |=> bankRowOpen == 4'h0)
    else $error("precharge all left rows");
  cs_ignore_a: assert property (cmdPins.csN && act
    |=> $stable(modeRegOut) && $stable(extModeRegOut))
    else $error("deselected command acted");
  lane_grain_a: assert property (dqOe[7:0] inside {8'h00, 8'hFF} &&
    dqOe[15:8] inside {8'h00, 8'hFF}) else $error("enable not per byte");
  down_float_a: assert property (!act && powerState != PWR_SUSPEND
    |-> dqOe == 16'h0000) else $error("driving in power down");
  wake_up_a: assert property (ckeIn && !act |=> act)
    else $error("no wake on enable high");
  act_down_a: assert property (!ckeIn && act && bankRowOpen != 4'h0
    && !burstActive |=> powerState == PWR_ACT_DN)
    else $error("wrong power state");
  buf_off_a: assert property (inputBuffersOn ==
    (act || powerState == PWR_SUSPEND)) else $error("buffer state wrong");
  low_mask_a: assert property (lowMasked |-> ##1 dqOe[7:0] == 8'h00)
    else $error("lower lane driven");
  up_mask_a: assert property (upMasked |-> ##1 dqOe[15:8] == 8'h00)
    else $error("upper lane driven");
endmodule // lps_sdram_if_checker

bind lps_sdram_if lps_sdram_if_checker #(
  .STORE_ROW_BITS(STORE_ROW_BITS), .STORE_COL_BITS(STORE_COL_BITS)
) i_chk (
  .sys_clk(sys_clk), .rst(rst), .ckeIn(ckeIn), .cmdPins(cmdPins),
  .bankSelect0(bankSelect0), .bankSelect1(bankSelect1), .addr(addr),
  .lowerByteMask(lowerByteMask), .upperByteMask(upperByteMask),
  .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .powerState(powerState),
  .inputBuffersOn(inputBuffersOn), .bankRowOpen(bankRowOpen),
  .burstActive(burstActive), .modeRegOut(modeRegOut),
  .extModeRegOut(extModeRegOut)
);

// File: tb/lps_sdram_if_tb.sv
`timescale 1ns/100ps

module lps_sdram_if_tb
  import lps_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ckeIn, bankSelect0, bankSelect1, lowerByteMask, upperByteMask;
  lps_cmd_pins_t cmdPins;
  logic [ADDR_W-1:0] addr, modeRegOut, extModeRegOut;
  logic [DQ_W-1:0] dqIn, dqOut, dqOe;
  lps_pwr_t powerState;
  logic inputBuffersOn, burstActive;
  logic [NUM_BANKS-1:0] bankRowOpen;
  logic [ADDR_W-1:0] modes [4] = '{13'h0020, 13'h0021, 13'h0032, 13'h0033};
  int bad_count = 0;
  int checked = 0;
  int first, cnt;

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  lps_sdram_if #(.STORE_ROW_BITS(2), .STORE_COL_BITS(4)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .ckeIn(ckeIn), .cmdPins(cmdPins),
    .bankSelect0(bankSelect0), .bankSelect1(bankSelect1), .addr(addr),
    .lowerByteMask(lowerByteMask), .upperByteMask(upperByteMask),
    .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .powerState(powerState),
    .inputBuffersOn(inputBuffersOn), .bankRowOpen(bankRowOpen),
    .burstActive(burstActive), .modeRegOut(modeRegOut),
    .extModeRegOut(extModeRegOut));

  lps_ctrl_model i_ctrl (
    .sys_clk(sys_clk), .ckeIn(ckeIn), .cmdPins(cmdPins),
    .bankSelect0(bankSelect0), .bankSelect1(bankSelect1), .addr(addr),
    .lowerByteMask(lowerByteMask), .upperByteMask(upperByteMask),
    .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));

  task automatic chkv(input string w, input logic [15:0] e,
      input logic [15:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic chks(input string w, input lps_pwr_t e);
    checked++;
    if (powerState !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", w, e, powerState);
    end
  endtask

  task automatic cmd(input lps_cmd_t c, input logic [1:0] b,
      input logic [ADDR_W-1:0] a, input logic [1:0] m, input logic k);
    i_ctrl.issue({1'b0, c}, b, a, m, k);
  endtask

  task automatic nop(input logic k);
    cmd(CMD_NOP, 2'h0, 13'h0000, 2'h0, k);
  endtask

  task automatic rows(input logic [3:0] e);
    chkv("rows", {12'h000, e}, {12'h000, bankRowOpen});
  endtask

  task automatic wr2(input logic [15:0] d0, d1, input logic [1:0] m0, m1);
    cmd(CMD_WRITE, 2'h2, 13'h0002, m0, 1'b1);
    i_ctrl.put(1'b1, d0);
    cmd(CMD_NOP, 2'h0, 13'h0000, m1, 1'b1);
    i_ctrl.put(1'b1, d1);
    nop(1'b1);
    i_ctrl.put(1'b0, 16'h0000);
  endtask

  task automatic rd2(input logic [12:0] a, input logic [1:0] m,
      input logic [15:0] e0, e1, oe1);
    cmd(CMD_READ, 2'h2, a, m, 1'b1);
    repeat (2) cmd(CMD_NOP, 2'h0, 13'h0000, m, 1'b1);
    chkv("beat0", e0 & oe1, dqOut & oe1);
    chkv("oe0", oe1, dqOe);
    nop(1'b1);
    chkv("beat1", e1 & oe1, dqOut & oe1);
    chkv("oe1", oe1, dqOe);
  endtask

  task automatic pwr(input lps_cmd_t c, input lps_pwr_t e, input logic bo);
    cmd(c, 2'h0, 13'h0000, 2'h0, 1'b0);
    nop(1'b0);
    chks("enter", e);
    chkv("buffers", {15'h0000, bo}, {15'h0000, inputBuffersOn});
    repeat (2) nop(1'b1);
    chks("exit", PWR_ACTIVE);
  endtask

  task automatic done(input string n);
    $display("test %s done, %0d checks, %0d mismatches", n, checked,
      bad_count);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #(25 * 4000);
    bad_count++;
    final_report;
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    chkv("mode reset", {3'h0, MODE_RST}, {3'h0, modeRegOut});
    rows(4'h0);
    i_ctrl.init(13'h0021, 13'h0005);
    chkv("mode", 16'h0021, {3'h0, modeRegOut});
    chkv("ext", 16'h0005, {3'h0, extModeRegOut});
    done("init");
    foreach (modes[i]) begin
      cmd(CMD_MODE_LOAD, SEL_MODE, modes[i], 2'h0, 1'b1);
      cmd(CMD_ACTIVATE, 2'h1, 13'h0001, 2'h0, 1'b1);
      cmd(CMD_READ, 2'h1, 13'h0000, 2'h0, 1'b1);
      first = 0;
      cnt = 0;
      for (int k = 1; k < 14; k++) begin
        nop(1'b1);
        if (k == 1) begin
          chkv("busy", {15'h0, |modes[i][2:0]}, {15'h0, burstActive});
        end
        if (dqOe !== 16'h0000) begin
          cnt++;
          if (first == 0) first = k;
        end
      end
      chkv("latency", {13'h0, modes[i][6:4]}, first[15:0]);
      chkv("length", 16'h0001 << modes[i][2:0], cnt[15:0]);
      chkv("idle", 16'h0000, {15'h0, burstActive});
      cmd(CMD_PRECHARGE, 2'h0, 13'h0400, 2'h0, 1'b1);
    end
    cmd(CMD_MODE_LOAD, SEL_MODE, 13'h0021, 2'h0, 1'b1);
    done("bursts");
    cmd(CMD_ACTIVATE, 2'h2, 13'h0001, 2'h0, 1'b1);
    cmd(CMD_ACTIVATE, 2'h1, 13'h0001, 2'h0, 1'b1);
    nop(1'b1);
    rows(4'h6);
    i_ctrl.issue({1'b1, CMD_PRECHARGE}, 2'h0, 13'h0400, 2'h0, 1'b1);
    nop(1'b1);
    rows(4'h6);
    wr2(16'h1234, 16'h5678, 2'h0, 2'h0);
    wr2(16'hAAAA, 16'hBBBB, 2'h2, 2'h1);
    rd2(13'h0003, 2'h0, 16'hBB78, 16'h12AA, 16'hFFFF);
    rd2(13'h0003, 2'h1, 16'hBB78, 16'h12AA, 16'hFF00);
    rd2(13'h0402, 2'h0, 16'h12AA, 16'hBB78, 16'hFFFF);
    rows(4'h2);
    cmd(CMD_ACTIVATE, 2'h0, 13'h0001, 2'h0, 1'b1);
    cmd(CMD_PRECHARGE, 2'h0, 13'h0000, 2'h0, 1'b1);
    nop(1'b1);
    rows(4'h2);
    cmd(CMD_PRECHARGE, 2'h2, 13'h0400, 2'h0, 1'b1);
    nop(1'b1);
    rows(4'h0);
    done("banks");
    cmd(CMD_ACTIVATE, 2'h2, 13'h0001, 2'h0, 1'b1);
    pwr(CMD_NOP, PWR_ACT_DN, 1'b0);
    cmd(CMD_READ, 2'h2, 13'h0002, 2'h0, 1'b1);
    pwr(CMD_NOP, PWR_SUSPEND, 1'b1);
    repeat (4) nop(1'b1);
    cmd(CMD_PRECHARGE, 2'h0, 13'h0400, 2'h0, 1'b1);
    pwr(CMD_NOP, PWR_PRE_DN, 1'b0);
    pwr(CMD_REFRESH, PWR_SELF_REF, 1'b0);
    pwr(CMD_TERMINATE, PWR_DEEP_DN, 1'b0);
    cmd(CMD_ACTIVATE, 2'h2, 13'h0001, 2'h0, 1'b1);
    rd2(13'h0002, 2'h0, 16'h0000, 16'h0000, 16'hFFFF);
    done("power");
    final_report;
  end
endmodule // lps_sdram_if_tb

// File: verilog/lps_pair_buf.sv
`timescale 1ns/100ps

module lps_pair_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] slot_r [DEPTH];
  logic [PTR_W-1:0] wrPtr_r;
  logic [PTR_W-1:0] rdPtr_r;
  logic [PTR_W:0] count_r;
  logic push;
  logic pop;

  assign inReady = count_r != (PTR_W + 1)'(DEPTH);
  assign outValid = count_r != '0;
  assign outData = slot_r[rdPtr_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
  endfunction

  always_ff @(posedge sys_clk) begin
    if (push) begin
      slot_r[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= step(wrPtr_r);
      end
      if (pop) begin
        rdPtr_r <= step(rdPtr_r);
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule // lps_pair_buf

// File: verilog/lps_pkg.sv
package lps_pkg;

  // array geometry at the pins
  localparam int DQ_W = 16;
  localparam int BYTE_W = 8;
  localparam int LANES = 2;
  localparam int ROW_W = 13;
  localparam int COL_W = 10;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int ADDR_W = 13;

  // address bit that carries the auto precharge / precharge-all flag
  localparam int AUTO_PRE_BIT = 10;

  // mode register field layout
  localparam int LEN_LSB = 0;
  localparam int LEN_W = 3;
  localparam int BT_BIT = 3;
  localparam int LAT_LSB = 4;
  localparam int LAT_W = 3;
  localparam int WB_BIT = 9;

  // burst length codes
  localparam logic [2:0] LEN_1 = 3'h0;
  localparam logic [2:0] LEN_2 = 3'h1;
  localparam logic [2:0] LEN_4 = 3'h2;
  localparam logic [2:0] LEN_8 = 3'h3;
  localparam logic [2:0] LEN_PAGE = 3'h7;

  // read latency codes
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_3 = 3'h3;

  // bank select values that pick a mode register on a load
  localparam logic [1:0] SEL_MODE = 2'h0;
  localparam logic [1:0] SEL_EXT = 2'h2;

  // reset contents of the mode registers
  localparam logic [ADDR_W-1:0] MODE_RST = 13'h0032;
  localparam logic [ADDR_W-1:0] EXT_RST = 13'h0000;

  // read output pipeline depth (longest latency less one)
  localparam int RD_STAGES = 2;
  // cycles from a sampled read mask to the drivers turning off
  localparam int MASK_LAT = 2;

  // command code on row, column and write strobes
  typedef enum logic [2:0] {
    CMD_MODE_LOAD = 3'h0,
    CMD_REFRESH = 3'h1,
    CMD_PRECHARGE = 3'h2,
    CMD_ACTIVATE = 3'h3,
    CMD_WRITE = 3'h4,
    CMD_READ = 3'h5,
    CMD_TERMINATE = 3'h6,
    CMD_NOP = 3'h7
  } lps_cmd_t;

  // power states, gray coded in the order listed; entry and exit go straight from and to active
  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'b000,
    PWR_SUSPEND = 3'b001,
    PWR_ACT_DN = 3'b011,
    PWR_PRE_DN = 3'b010,
    PWR_SELF_REF = 3'b110,
    PWR_DEEP_DN = 3'b111
  } lps_pwr_t;

  // command pins, all active low
  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
  } lps_cmd_pins_t;

  // one read beat in the output pipeline
  typedef struct packed {
    logic valid;
    logic [DQ_W-1:0] data;
  } lps_beat_t;

endpackage

// File: verilog/lps_sdram_if.sv
`timescale 1ns/100ps

module lps_sdram_if
  import lps_pkg::*;
#(
  parameter int STORE_ROW_BITS = 2,
  parameter int STORE_COL_BITS = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // command and address pins
  input wire logic ckeIn,
  input wire lps_cmd_pins_t cmdPins,
  input wire logic bankSelect0,
  input wire logic bankSelect1,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic lowerByteMask,
  input wire logic upperByteMask,
  // data bus
  input wire logic [DQ_W-1:0] dqIn,
  output logic [DQ_W-1:0] dqOut,
  output logic [DQ_W-1:0] dqOe,
  // status
  output lps_pwr_t powerState,
  output logic inputBuffersOn,
  output logic [NUM_BANKS-1:0] bankRowOpen,
  output logic burstActive,
  output logic [ADDR_W-1:0] modeRegOut,
  output logic [ADDR_W-1:0] extModeRegOut
);

  localparam int IDX_W = BANK_W + STORE_ROW_BITS + STORE_COL_BITS;
  localparam int MEM_WORDS = 1 << IDX_W;

  lps_pwr_t pwr_r;
  lps_pwr_t pwr_nxt;
  lps_cmd_t rawCmd;
  lps_cmd_t cmd;
  logic cmdLive;
  logic adv;
  logic [BANK_W-1:0] bankSel;
  logic [COL_W-1:0] cmdCol;
  logic allIdle;

  logic [ADDR_W-1:0] modeReg_r;
  logic [ADDR_W-1:0] extMode_r;
  logic [2:0] lenCode;
  logic interleave;
  logic wbSingle;
  logic latThree;

  logic [NUM_BANKS-1:0] rowOpen_r;
  logic [ROW_W-1:0] openRow_r [NUM_BANKS];

  logic rdActive_r;
  logic wrActive_r;
  logic [BANK_W-1:0] burstBank_r;
  logic [COL_W-1:0] startCol_r;
  logic [COL_W-1:0] beat_r;
  logic [COL_W-1:0] burstMask_r;
  logic fullPage_r;
  logic burstClose_r;
  logic [COL_W-1:0] curCol;
  logic rdStep;
  logic wrStep;
  logic burstLast;
  logic endClose;
  logic cmdClose;
  logic stopBurst;

  logic [DQ_W-1:0] mem [MEM_WORDS];
  logic [IDX_W-1:0] rdIdx;
  logic [IDX_W-1:0] wrIdx;
  logic wrEn;
  logic [LANES-1:0] wrMask;
  logic pushRd;
  logic bufInReady;
  logic bufOutValid;
  logic [DQ_W-1:0] bufOutData;

  lps_beat_t pipe_r [RD_STAGES];
  logic [LANES-1:0] maskDly_r [MASK_LAT];
  lps_beat_t outBeat;
  logic driversOn;

  // command decode from select plus strobes
  function automatic lps_cmd_t decodeCmd(input lps_cmd_pins_t p);
    if (p.csN) begin
      return CMD_NOP;
    end
    return lps_cmd_t'({p.rasN, p.casN, p.weN});
  endfunction

  // wrap mask of a burst, from the length code
  function automatic logic [COL_W-1:0] lenMask(input logic [2:0] code);
    unique case (code)
      LEN_1: return COL_W'(0);
      LEN_2: return COL_W'(1);
      LEN_4: return COL_W'(3);
      LEN_8: return COL_W'(7);
      LEN_PAGE: return '1;
      default: return COL_W'(0);
    endcase
  endfunction

  // column of a given beat, sequential or interleaved
  function automatic logic [COL_W-1:0] burstCol(
    input logic [COL_W-1:0] start,
    input logic [COL_W-1:0] beat,
    input logic [COL_W-1:0] mask,
    input logic ilv
  );
    logic [COL_W-1:0] off;
    off = ilv ? (start ^ beat) : (start + beat);
    return (start & ~mask) | (off & mask);
  endfunction

  // storage index of bank, row and column
  function automatic logic [IDX_W-1:0] memIdx(
    input logic [BANK_W-1:0] b,
    input logic [ROW_W-1:0] r,
    input logic [COL_W-1:0] c
  );
    return {b, r[STORE_ROW_BITS-1:0], c[STORE_COL_BITS-1:0]};
  endfunction

  assign bankSel = {bankSelect1, bankSelect0};
  assign cmdCol = addr[COL_W-1:0];
  assign allIdle = rowOpen_r == '0;
  assign rawCmd = decodeCmd(cmdPins);
  // the decoded command is forced to NOP unless fully active with the clock enabled
  assign cmdLive = ckeIn && (pwr_r == PWR_ACTIVE);
  assign cmd = cmdLive ? rawCmd : CMD_NOP;
  assign adv = ckeIn && (pwr_r == PWR_ACTIVE || pwr_r == PWR_SUSPEND);

  assign lenCode = modeReg_r[LEN_LSB +: LEN_W];
  assign interleave = modeReg_r[BT_BIT] && (lenCode != LEN_PAGE);
  assign wbSingle = modeReg_r[WB_BIT];
  assign latThree = modeReg_r[LAT_LSB +: LAT_W] != LAT_2;

  // power state selection
  always_comb begin
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      PWR_ACTIVE: begin
        if (!ckeIn) begin
          if (rdActive_r || wrActive_r) begin
            pwr_nxt = PWR_SUSPEND;
          end else if (rawCmd == CMD_REFRESH && allIdle) begin
            pwr_nxt = PWR_SELF_REF;
          end else if (rawCmd == CMD_TERMINATE && allIdle) begin
            pwr_nxt = PWR_DEEP_DN;
          end else if (!allIdle) begin
            pwr_nxt = PWR_ACT_DN;
          end else begin
            pwr_nxt = PWR_PRE_DN;
          end
        end
      end
      PWR_SUSPEND, PWR_ACT_DN, PWR_PRE_DN, PWR_SELF_REF, PWR_DEEP_DN: begin
        if (ckeIn) begin
          pwr_nxt = PWR_ACTIVE;
        end
      end
      default: pwr_nxt = PWR_ACTIVE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwr_r <= PWR_ACTIVE;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // mode registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      modeReg_r <= MODE_RST;
      extMode_r <= EXT_RST;
    end else if (cmd == CMD_MODE_LOAD) begin
      if (bankSel == SEL_MODE) begin
        modeReg_r <= addr;
      end else if (bankSel == SEL_EXT) begin
        extMode_r <= addr;
      end
    end
  end

  // burst control
  assign curCol = burstCol(startCol_r, beat_r, burstMask_r, interleave);
  assign rdStep = rdActive_r && adv && bufInReady;
  assign wrStep = wrActive_r && adv;
  assign burstLast = !fullPage_r && (beat_r == burstMask_r);
  assign endClose = (rdStep || wrStep) && burstLast && burstClose_r;
  assign stopBurst = cmd == CMD_TERMINATE ||
    (cmd == CMD_PRECHARGE &&
     (addr[AUTO_PRE_BIT] || bankSel == burstBank_r));
  assign cmdClose = addr[AUTO_PRE_BIT] &&
    ((cmd == CMD_READ && lenMask(lenCode) == '0) ||
     (cmd == CMD_WRITE && (wbSingle || lenMask(lenCode) == '0)));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdActive_r <= 1'b0;
      wrActive_r <= 1'b0;
      burstBank_r <= '0;
      startCol_r <= '0;
      beat_r <= '0;
      burstMask_r <= '0;
      fullPage_r <= 1'b0;
      burstClose_r <= 1'b0;
    end else if (cmd == CMD_READ || cmd == CMD_WRITE) begin
      burstBank_r <= bankSel;
      startCol_r <= cmdCol;
      beat_r <= COL_W'(1);
      burstClose_r <= addr[AUTO_PRE_BIT];
      fullPage_r <= lenCode == LEN_PAGE;
      if (cmd == CMD_WRITE && wbSingle) begin
        burstMask_r <= '0;
        rdActive_r <= 1'b0;
        wrActive_r <= 1'b0;
      end else begin
        burstMask_r <= lenMask(lenCode);
        rdActive_r <= cmd == CMD_READ && lenMask(lenCode) != '0;
        wrActive_r <= cmd == CMD_WRITE && lenMask(lenCode) != '0;
      end
    end else if (stopBurst) begin
      rdActive_r <= 1'b0;
      wrActive_r <= 1'b0;
    end else if (rdStep || wrStep) begin
      beat_r <= beat_r + 1'b1;
      if (burstLast) begin
        rdActive_r <= 1'b0;
        wrActive_r <= 1'b0;
      end
    end
  end

  // per-bank row state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rowOpen_r <= '0;
      for (int b = 0; b < NUM_BANKS; b++) begin
        openRow_r[b] <= '0;
      end
    end else if (pwr_nxt == PWR_DEEP_DN && pwr_r == PWR_ACTIVE) begin
      rowOpen_r <= '0;
    end else begin
      if (endClose) begin
        rowOpen_r[burstBank_r] <= 1'b0;
      end
      if (cmdClose) begin
        rowOpen_r[bankSel] <= 1'b0;
      end
      if (cmd == CMD_PRECHARGE) begin
        if (addr[AUTO_PRE_BIT]) begin
          rowOpen_r <= '0;
        end else begin
          rowOpen_r[bankSel] <= 1'b0;
        end
      end
      if (cmd == CMD_ACTIVATE) begin
        rowOpen_r[bankSel] <= 1'b1;
        openRow_r[bankSel] <= addr[ROW_W-1:0];
      end
    end
  end

  // array write path
  assign wrEn = cmd == CMD_WRITE || wrStep;
  assign wrIdx = (cmd == CMD_WRITE) ?
    memIdx(bankSel, openRow_r[bankSel], cmdCol) :
    memIdx(burstBank_r, openRow_r[burstBank_r], curCol);
  assign wrMask = {upperByteMask, lowerByteMask};

  always_ff @(posedge sys_clk) begin
    if (pwr_nxt == PWR_DEEP_DN && pwr_r == PWR_ACTIVE) begin
      for (int w = 0; w < MEM_WORDS; w++) begin
        mem[w] <= '0;
      end
    end else if (wrEn) begin
      for (int l = 0; l < LANES; l++) begin
        if (!wrMask[l]) begin
          mem[wrIdx][l*BYTE_W +: BYTE_W] <= dqIn[l*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  // array read path into the two-entry buffer
  assign pushRd = cmd == CMD_READ || rdStep;
  assign rdIdx = (cmd == CMD_READ) ?
    memIdx(bankSel, openRow_r[bankSel], cmdCol) :
    memIdx(burstBank_r, openRow_r[burstBank_r], curCol);

  lps_pair_buf #(
    .WIDTH(DQ_W),
    .DEPTH(2)
  ) u_rd_buf (
    .sys_clk(sys_clk),
    .rst(rst),
    .inValid(pushRd),
    .inReady(bufInReady),
    .inData(mem[rdIdx]),
    .outValid(bufOutValid),
    .outReady(adv),
    .outData(bufOutData)
  );

  // latency pipeline and read mask delay
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int s = 0; s < RD_STAGES; s++) begin
        pipe_r[s] <= '0;
      end
    end else if (adv) begin
      pipe_r[0] <= {bufOutValid, bufOutData};
      for (int s = 1; s < RD_STAGES; s++) begin
        pipe_r[s] <= pipe_r[s-1];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int s = 0; s < MASK_LAT; s++) begin
        maskDly_r[s] <= '1;
      end
    end else if (adv) begin
      maskDly_r[0] <= wrMask;
      for (int s = 1; s < MASK_LAT; s++) begin
        maskDly_r[s] <= maskDly_r[s-1];
      end
    end
  end

  // output drivers
  assign outBeat = latThree ? pipe_r[1] : pipe_r[0];
  assign driversOn = pwr_r == PWR_ACTIVE;
  assign dqOut = outBeat.data;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign dqOe[g*BYTE_W +: BYTE_W] = {BYTE_W{outBeat.valid && driversOn &&
        !maskDly_r[MASK_LAT-1][g]}};
    end
  endgenerate

  // status
  assign powerState = pwr_r;
  assign inputBuffersOn = pwr_r == PWR_ACTIVE || pwr_r == PWR_SUSPEND;
  assign bankRowOpen = rowOpen_r;
  assign burstActive = rdActive_r || wrActive_r;
  assign modeRegOut = modeReg_r;
  assign extModeRegOut = extMode_r;

endmodule // lps_sdram_if
